//--- rtl/fpb_core.sv
/*
 * fetch/execute pipeline with flush, two-word trailers and banked
 * data addressing, plus a small register port.
 * assumes program memory answers combinationally on progAddr and
 * data memory returns read data in the cycle after dmReq.re.
 */
`timescale 1ns/10ps
`default_nettype none
`include "fpb_defs.svh"

module fpb_core #(
    parameter logic [4:0] NUM_LOW_BANKS = 5'd2
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    // program memory
    output logic [20:0] progAddr,
    input wire logic [15:0] progData,
    // data memory
    output fpb_pkg::fpb_dreq_t dmReq,
    input wire logic [7:0] dmRdata,
    // status
    output logic [3:0] qPhase,
    output logic firstQuarter
);

    // window needs no bank select
    // banked or window address of an 8-bit operand
    function automatic logic [11:0] fpb_daddr(
        input logic acc,
        input logic [7:0] off,
        input logic [3:0] bank
    );
        logic [3:0] hi;
        hi = `FPB_LOW_BANK;
        if (acc) begin
            hi = bank;
        end else if (off >= `FPB_WIN_SPLIT) begin
            hi = `FPB_TOP_BANK;
        end
        return {hi, off};
    endfunction

    // top four bits name the bank
    // whether a data address falls in a bank that exists
    function automatic logic fpb_impl(input logic [11:0] a);
        return ({1'b0, a[11:8]} < NUM_LOW_BANKS) || (a[11:8] == `FPB_TOP_BANK);
    endfunction

    // state
    fpb_pkg::fpb_phase_t ph_r;
    fpb_pkg::fpb_phase_t ph_nxt;
    logic [19:0] pcWord_r;
    logic [19:0] pcWord_nxt;
    logic [15:0] ir_r;
    logic irValid_r;
    logic pendGoto_r;
    logic pendMove_r;
    logic [7:0] pendLit_r;
    logic [7:0] rdByte_r;
    logic [7:0] wreg_r;
    logic zeroFlag_r;
    logic negFlag_r;
    logic [3:0] bank_r;
    logic run_r;
    fpb_pkg::fpb_dreq_t dmReq_r;
    logic [31:0] regRdata_r;

    // phase strobes
    wire atQ1 = (ph_r == fpb_pkg::PH_Q1);
    wire atQ3 = (ph_r == fpb_pkg::PH_Q3);
    wire atQ4 = (ph_r == fpb_pkg::PH_Q4);

    // decode of the instruction register
    wire pend = pendGoto_r | pendMove_r;
    wire isTrail = (ir_r[15:12] == `FPB_TRAILER);
    // a lone trailer decodes as no operation
    wire live = irValid_r & ~pend & ~isTrail;
    wire accBit = ir_r[8];
    wire dirBit = ir_r[9];
    wire opLbank = live & (ir_r[15:8] == `FPB_OP_LBANK);
    wire opMovlw = live & (ir_r[15:8] == `FPB_OP_MOVLW);
    wire opGoto1 = live & (ir_r[15:8] == `FPB_OP_GOTO);
    wire opBra = live & (ir_r[15:11] == `FPB_OP_BRA);
    wire opFmove1 = live & (ir_r[15:12] == `FPB_OP_FMOVE);
    wire opTstz = live & (ir_r[15:9] == `FPB_OP_TSTZ);
    wire opMovwf = live & (ir_r[15:9] == `FPB_OP_MOVWF);
    wire opMovf = live & (ir_r[15:10] == `FPB_OP_MOVF);
    wire doGoto = irValid_r & pendGoto_r & isTrail;
    wire doMove = irValid_r & pendMove_r & isTrail;

    // window or bank select for short operands
    wire [11:0] shortAddr = fpb_daddr(accBit, ir_r[7:0], bank_r);
    // full address move ignores bank select
    wire [11:0] rdAddr = opFmove1 ? ir_r[11:0] : shortAddr;
    wire [11:0] wrAddr = doMove ? ir_r[11:0] : shortAddr;
    wire needRd = opTstz | opMovf | opFmove1;
    wire needWr = opMovwf | (opMovf & dirBit) | doMove;
    wire [7:0] wrData = opMovwf ? wreg_r : rdByte_r;
    // pc low byte lives in the data map
    wire rdPcl = (rdAddr == `FPB_PCL_ADDR);
    wire wrPcl = needWr & (wrAddr == `FPB_PCL_ADDR);
    wire rdOk = fpb_impl(rdAddr);
    wire wrOk = fpb_impl(wrAddr) & ~wrPcl;
    // read value as it arrives; a read-back write must not use the byte latched last cycle
    wire [7:0] rdVal = rdPcl ? {pcWord_r[6:0], 1'b0} : (rdOk ? dmRdata : 8'h00);
    wire [7:0] wrByte = opMovf ? rdVal : wrData;

    // offset counts words, sign extended to the word pc
    wire [19:0] braWord = pcWord_r + {{9{ir_r[10]}}, ir_r[10:0]};
    // word address into pc bits 20..1
    wire [19:0] gotoWord = {ir_r[11:0], pendLit_r};
    // a change of flow flushes the word fetched meanwhile
    wire flush = opBra | doGoto | wrPcl;
    wire skip = opTstz & (rdByte_r == 8'h00);
    wire killNext = flush | skip;

    // four quarter phases; halting only between cycles
    always_comb begin
        case (ph_r)
            fpb_pkg::PH_Q1: ph_nxt = run_r ? fpb_pkg::PH_Q2 : fpb_pkg::PH_Q1;
            fpb_pkg::PH_Q2: ph_nxt = fpb_pkg::PH_Q3;
            fpb_pkg::PH_Q3: ph_nxt = fpb_pkg::PH_Q4;
            fpb_pkg::PH_Q4: ph_nxt = fpb_pkg::PH_Q1;
            default: ph_nxt = fpb_pkg::PH_Q1;
        endcase
    end

    // next fetch address
    always_comb begin
        pcWord_nxt = pcWord_r + 20'h00001;
        if (opBra) begin
            pcWord_nxt = braWord;
        end else if (doGoto) begin
            pcWord_nxt = gotoWord;
        end else if (wrPcl) begin
            pcWord_nxt = {pcWord_r[19:7], wrData[7:1]};
        end
    end

    // phase divider
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ph_r <= fpb_pkg::PH_Q1;
        end else begin
            ph_r <= ph_nxt;
        end
    end

    // pc held as word address, so bit 0 is always zero
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pcWord_r <= `FPB_PC_RST;
        end else if (atQ4) begin
            pcWord_r <= pcWord_nxt;
        end
    end

    // fetch word latched into the instruction register at Q4
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ir_r <= 16'h0000;
            irValid_r <= 1'b0;
        end else if (atQ4) begin
            ir_r <= progData;
            irValid_r <= ~killNext;
        end
    end

    // two-word first halves wait for their trailer
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pendGoto_r <= 1'b0;
            pendMove_r <= 1'b0;
            pendLit_r <= 8'h00;
        end else if (atQ4) begin
            pendGoto_r <= opGoto1;
            pendMove_r <= opFmove1;
            pendLit_r <= ir_r[7:0];
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdByte_r <= 8'h00;
        end else if (atQ3 && needRd) begin
            rdByte_r <= rdVal;
        end
    end

    // data memory strobes: read in Q2, write in Q4
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dmReq_r <= '0;
        end else begin
            dmReq_r.re <= atQ1 & run_r & needRd & rdOk & ~rdPcl;
            dmReq_r.we <= atQ3 & needWr & wrOk;
            if (atQ1) begin
                dmReq_r.addr <= rdAddr;
            end else if (atQ3) begin
                dmReq_r.addr <= wrAddr;
                dmReq_r.wdata <= wrByte;
            end
        end
    end

    // flags follow the read value even for missing banks
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wreg_r <= 8'h00;
            zeroFlag_r <= 1'b0;
            negFlag_r <= 1'b0;
        end else if (atQ4) begin
            if (opMovlw) begin
                wreg_r <= ir_r[7:0];
            end else if (opMovf) begin
                if (!dirBit) begin
                    wreg_r <= rdByte_r;
                end
                zeroFlag_r <= (rdByte_r == 8'h00);
                negFlag_r <= rdByte_r[7];
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            bank_r <= `FPB_BANK_RST;
        end else if (atQ4 && opLbank) begin
            bank_r <= ir_r[3:0];
        end else if (regWr && regAddr == `FPB_REG_BANK) begin
            bank_r <= regWdata[3:0];
        end
    end

    // run control; a halt waits for the start of a cycle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            run_r <= `FPB_RUN_RST;
        end else if (regWr && regAddr == `FPB_REG_CTRL) begin
            run_r <= regWdata[0];
        end
    end

    // register read selection, unmapped offsets give zero
    wire selCtrl = (regAddr == `FPB_REG_CTRL);
    wire selBank = (regAddr == `FPB_REG_BANK);
    wire selPc = (regAddr == `FPB_REG_PC);
    wire selWreg = (regAddr == `FPB_REG_WREG);
    wire selStat = (regAddr == `FPB_REG_STAT);
    wire [31:0] rdMux =
        selCtrl ? {31'h00000000, run_r} :
        selBank ? {28'h0000000, bank_r} :
        selPc ? {11'h000, pcWord_r, 1'b0} :
        selWreg ? {24'h000000, wreg_r} :
        selStat ? {30'h00000000, negFlag_r, zeroFlag_r} :
        32'h00000000;

    // read data stands one cycle after the strobe
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            regRdata_r <= 32'h00000000;
        end else begin
            regRdata_r <= regRd ? rdMux : 32'h00000000;
        end
    end

    // outputs
    assign regRdata = regRdata_r;
    assign progAddr = {pcWord_r, 1'b0};
    assign dmReq = dmReq_r;
    assign qPhase = ph_r;
    assign firstQuarter = atQ1;

endmodule
`default_nettype wire

//--- rtl/fpb_defs.svh
/*
 * constants of the fetch pipeline and bank addressing front end:
 * register port offsets, reset values, opcode patterns, map limits.
 * assumes it is included by bare name, after fpb_pkg is compiled.
 */
`ifndef FPB_DEFS_SVH
`define FPB_DEFS_SVH

// register port offsets
`define FPB_REG_CTRL 8'h00
`define FPB_REG_BANK 8'h04
`define FPB_REG_PC 8'h08
`define FPB_REG_WREG 8'h0c
`define FPB_REG_STAT 8'h10

// reset values
`define FPB_PC_RST 20'h00000
`define FPB_BANK_RST 4'h0
`define FPB_RUN_RST 1'b1

// data map
`define FPB_PCL_ADDR 12'hff9
`define FPB_WIN_SPLIT 8'h60
`define FPB_LOW_BANK 4'h0
`define FPB_TOP_BANK 4'hf

// opcode patterns
`define FPB_TRAILER 4'hf
`define FPB_OP_LBANK 8'h01
`define FPB_OP_MOVLW 8'h0e
`define FPB_OP_GOTO 8'hef
`define FPB_OP_BRA 5'h1a
`define FPB_OP_FMOVE 4'hc
`define FPB_OP_TSTZ 7'h33
`define FPB_OP_MOVWF 7'h37
`define FPB_OP_MOVF 6'h14

`endif

//--- rtl/fpb_pkg.sv
/*
 * types shared by the front end: quarter phase states and the
 * data memory request bundle.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package fpb_pkg;

    // quarter phases of one instruction cycle
    typedef enum logic [3:0] {
        PH_Q1 = 4'b0001,
        PH_Q2 = 4'b0010,
        PH_Q3 = 4'b0100,
        PH_Q4 = 4'b1000
    } fpb_phase_t;

    // data memory request, driven from flip-flops
    typedef struct packed {
        logic [11:0] addr;
        logic [7:0] wdata;
        logic we;
        logic re;
    } fpb_dreq_t;

endpackage

//--- test/fpb_core_properties.sv
/*
 * port checker for fpb_core: phases, fetch address, data strobes.
 * assumes one clock, mclk, and async active-low rst_n.
 */
`timescale 1ns/10ps
`default_nettype none
module fpb_core_properties #(
    parameter logic [4:0] NUM_LOW_BANKS = 5'd2
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [31:0] regRdata,
    // memories and status
    input wire logic [20:0] progAddr,
    input wire logic [15:0] progData,
    input wire fpb_pkg::fpb_dreq_t dmReq,
    input wire logic [7:0] dmRdata,
    input wire logic [3:0] qPhase,
    input wire logic firstQuarter
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // phase sequence; q1 may stall while halted, so start at q2
    a_phase_onehot: assert property ($onehot(qPhase)) else $error("phase not one-hot");
    a_phase_order: assert property (qPhase == 4'b0010 |=> qPhase == 4'b0100 ##1 qPhase == 4'b1000
        ##1 qPhase == 4'b0001) else $error("phase order broken");
    a_first_qtr: assert property (firstQuarter == (qPhase == 4'b0001)) else $error("q1 flag wrong");
    // fetch address
    a_pc_even: assert property (progAddr[0] == 1'b0) else $error("odd fetch address");
    a_pc_hold: assert property (qPhase != 4'b1000 |=> $stable(progAddr)) else $error("fetch moved");
    // data strobes
    a_read_q2: assert property (dmReq.re |-> qPhase == 4'b0010) else $error("read off q2");
    a_write_q4: assert property (dmReq.we |-> qPhase == 4'b1000 && !dmReq.re) else $error("write off q4");
    a_bank_impl: assert property ((dmReq.re || dmReq.we) |->
        ({1'b0, dmReq.addr[11:8]} < NUM_LOW_BANKS || dmReq.addr[11:8] == 4'hf)) else $error("strobe to absent bank");
    a_pcl_inside: assert property ((dmReq.re || dmReq.we) |-> dmReq.addr != 12'hff9)
        else $error("pc low strobed out");
    a_bank_upper: assert property ($past(regRd) && $past(regAddr) == 8'h04 |-> regRdata[31:4] == 28'h0)
        else $error("bank upper bits set");
    c_write: cover property (dmReq.we);
    c_read: cover property (dmReq.re);
    c_jump: cover property (qPhase == 4'b1000 ##1 progAddr != $past(progAddr) + 21'h2);
endmodule
bind fpb_core fpb_core_properties #(.NUM_LOW_BANKS(NUM_LOW_BANKS)) u_props (.mclk(mclk), .rst_n(rst_n),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .progAddr(progAddr), .progData(progData), .dmReq(dmReq), .dmRdata(dmRdata), .qPhase(qPhase),
    .firstQuarter(firstQuarter));
`default_nettype wire

//--- test/fpb_core_tb.sv
/*
 * bench: runs a program, then checks memory and registers.
 * assumes fpb_core, fpb_mem_model and the checker are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none
`define FPB_CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; \
    $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module fpb_core_tb;
    logic mclk, rst_n, regWr, regRd, firstQuarter;
    logic [7:0] regAddr, dmRdata;
    logic [31:0] regWdata, regRdata, rd;
    logic [20:0] progAddr;
    logic [15:0] progData;
    logic [3:0] qPhase;
    fpb_pkg::fpb_dreq_t dmReq;
    int errors, comparisons;
    // program: stores, skip, move, goto, branches, absent-bank flags
    logic [15:0] prog [0:21] = '{16'h0e55, 16'h0102, 16'h6f10, 16'h0101, 16'h6f20, 16'h6e70, 16'h6e05,
        16'h6640, 16'hc120, 16'hf031, 16'hc120, 16'hf030, 16'hef0f, 16'hf000, 16'h0e99, 16'h6e06,
        16'hd001, 16'h0e99, 16'h6e07, 16'h0102, 16'h5310, 16'hd7ff};
    fpb_core i_dut (.mclk(mclk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .progAddr(progAddr), .progData(progData), .dmReq(dmReq),
        .dmRdata(dmRdata), .qPhase(qPhase), .firstQuarter(firstQuarter));
    fpb_mem_model i_mem (.mclk(mclk), .progAddr(progAddr), .progData(progData), .dmReq(dmReq),
        .dmRdata(dmRdata));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        regAddr <= a; regWdata <= d; regWr <= 1'b1;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic reg_read(input logic [7:0] a);
        @(posedge mclk);
        regAddr <= a; regRd <= 1'b1;
        @(posedge mclk);
        regRd <= 1'b0;
        #1 rd = regRdata;
    endtask
    task automatic final_report;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // main sequence
    initial begin
        rst_n = 1'b0; regWr = 1'b0; regRd = 1'b0; regAddr = 8'h00; regWdata = 32'h0;
        for (int i = 0; i < 64; i++) i_mem.rom[i] = (i < 22) ? prog[i] : 16'h0000;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        reg_read(8'h04); `FPB_CHK("bank reset", 32'h0, rd)
        reg_read(8'h00); `FPB_CHK("ctrl reset", 32'h1, rd)
        repeat (300) @(posedge mclk);
        `FPB_CHK("banked 120", 8'h55, i_mem.ram[12'h120])
        `FPB_CHK("window f70", 8'h55, i_mem.ram[12'hf70])
        `FPB_CHK("window 005", 8'h55, i_mem.ram[12'h005])
        `FPB_CHK("absent bank", 8'h00, i_mem.ram[12'h210])
        `FPB_CHK("move dst", 8'h55, i_mem.ram[12'h030])
        `FPB_CHK("lone trailer", 8'h00, i_mem.ram[12'h031])
        `FPB_CHK("after goto", 8'h55, i_mem.ram[12'h006])
        `FPB_CHK("after bra", 8'h55, i_mem.ram[12'h007])
        reg_read(8'h0c); `FPB_CHK("w flushed", 32'h55, rd)
        reg_read(8'h10); `FPB_CHK("flags", 32'h1, rd)
        reg_read(8'h04); `FPB_CHK("bank literal", 32'h2, rd)
        reg_write(8'h04, 32'hffffff3e);
        reg_read(8'h04); `FPB_CHK("bank upper", 32'he, rd)
        reg_read(8'h20); `FPB_CHK("unmapped", 32'h0, rd)
        reg_read(8'h08); `FPB_CHK("pc bit0", 1'b0, rd[0])
        reg_write(8'h00, 32'h0);
        repeat (8) @(posedge mclk); `FPB_CHK("halt", 4'h1, qPhase)
        final_report;
    end
    // watchdog
    initial begin
        repeat (2000) @(posedge mclk);
        errors++;
        final_report;
    end
endmodule
`default_nettype wire

//--- test/fpb_mem_model.sv
/*
 * program and data memory model beside fpb_core.
 * assumes the bench fills rom before reset is released.
 */
`timescale 1ns/10ps
`default_nettype none
module fpb_mem_model (
    // clock
    input wire logic mclk,
    // program side
    input wire logic [20:0] progAddr,
    output logic [15:0] progData,
    // data side
    input wire fpb_pkg::fpb_dreq_t dmReq,
    output logic [7:0] dmRdata
);
    logic [15:0] rom [0:63];
    logic [7:0] ram [0:4095];
    assign progData = rom[progAddr[6:1]];
    initial begin
        for (int i = 0; i < 4096; i++) ram[i] = 8'h00;
    end
    // twelve-bit data address
    // read data stands one cycle, then toggles so stale data looks invalid
    always @(posedge mclk) begin
        dmRdata <= dmReq.re ? ram[dmReq.addr] : ~dmRdata;
        if (dmReq.we) ram[dmReq.addr] <= dmReq.wdata;
    end
endmodule
`default_nettype wire
